// ==== design/gyro_register_map_readout.sv ====
// register map, auto-increment pointer and output-sample read-out of the rate sensor
`timescale 1ns/1ps
module gyro_register_map_readout import gyro_regs_pkg::*; #(
	parameter logic [7:0] IDENTITY_CODE = 8'h5a // arbitrary value
) (
	input wire logic clk,
	input wire logic rst_n,
	// register access from the serial protocol engine
	input wire logic acc_start,
	input wire logic [7:0] acc_addr,
	input wire logic acc_stop,
	input wire logic acc_rd,
	input wire logic acc_wr,
	input wire logic [7:0] acc_wdata,
	output logic [7:0] acc_rdata,
	output logic acc_rvalid,
	output logic [7:0] acc_ptr,
	// new acquisitions from the signal chain
	input wire logic smp_valid,
	input wire sample_s smp_data,
	output logic smp_ready,
	// head of the sample buffer
	input wire sample_s head_data,
	output logic head_pop,
	// status from neighbouring blocks
	input wire ext_status_s ext_status,
	output config_s cfg,
	output logic soft_reset_pulse
);
	typedef struct packed {
		xfer_e xfer;
		logic [7:0] ptr;
		logic [7:0] rdata;
		logic rvalid;
		logic pop;
		logic srst;
		config_s cfg;
		logic [5:0][7:0] out;
		logic [2:0][7:0] live_low;
		logic [7:0] dr;
		logic [BUF_DEPTH-1:0][47:0] fifo;
		logic [1:0] count;
	} state_s;

	logic rst_sync1_q;
	logic rst_sync2_q;
	state_s s_q;
	state_s s_d;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	function automatic logic [7:0] next_addr(input logic [7:0] a, input logic wrap_one);
		if (a == ADDR_Z_RATE_LOW) begin
			next_addr = wrap_one ? ADDR_X_RATE_HIGH : ADDR_STATUS_ALIAS;
		end else if (a == ADDR_WRAP_POWER_RANGE_CONTROL) begin
			next_addr = ADDR_STATUS_ALIAS;
		end else begin
			next_addr = a + 8'h01;
		end
	endfunction : next_addr

	function automatic config_s config_reset();
		config_s c;
		c = '0;
		c.buffer_setup = RST_ZERO;
		c.threshold_debounce = RST_THRESHOLD_DEBOUNCE;
		config_reset = c;
	endfunction : config_reset

	logic bypass;
	logic drain;
	logic [1:0] axis_hi_read;
	logic hi_read;
	logic [47:0] head_bytes;
	logic [47:0] fifo_out;
	logic [7:0] rd_val;

	assign bypass = s_q.cfg.buffer_setup[BUF_MODE_LSB +: 2] == BUF_MODE_BYPASS;
	assign head_bytes = head_data;
	assign fifo_out = s_q.fifo[0];
	// samples wait while a burst is open so the six bytes stay coherent
	assign drain = (s_q.count != 2'd0) && (s_q.xfer == XFER_IDLE);
	assign smp_ready = s_q.count != 2'(BUF_DEPTH);

	always_comb begin
		hi_read = 1'b0;
		axis_hi_read = 2'd0;
		// a read that shares its cycle with start or stop is ignored, so it must not clear or pop
		if (acc_rd && !acc_start && !acc_stop && s_q.xfer == XFER_BURST) begin
			case (s_q.ptr)
				ADDR_X_RATE_HIGH: begin
					hi_read = 1'b1;
					axis_hi_read = 2'd0;
				end
				ADDR_Y_RATE_HIGH: begin
					hi_read = 1'b1;
					axis_hi_read = 2'd1;
				end
				ADDR_Z_RATE_HIGH: begin
					hi_read = 1'b1;
					axis_hi_read = 2'd2;
				end
				default: begin
					hi_read = 1'b0;
					axis_hi_read = 2'd0;
				end
			endcase
		end
	end

	always_comb begin
		rd_val = RST_ZERO;
		case (s_q.ptr)
			ADDR_STATUS_ALIAS: rd_val = bypass ? s_q.dr : ext_status.buffer_status;
			ADDR_X_RATE_HIGH: rd_val = bypass ? s_q.out[5] : head_bytes[47:40];
			ADDR_X_RATE_LOW: rd_val = s_q.out[4];
			ADDR_Y_RATE_HIGH: rd_val = s_q.out[3];
			ADDR_Y_RATE_LOW: rd_val = s_q.out[2];
			ADDR_Z_RATE_HIGH: rd_val = s_q.out[1];
			ADDR_Z_RATE_LOW: rd_val = s_q.out[0];
			ADDR_SAMPLE_READY_STATUS: rd_val = s_q.dr;
			ADDR_BUFFER_STATUS: rd_val = ext_status.buffer_status;
			ADDR_BUFFER_SETUP: rd_val = s_q.cfg.buffer_setup;
			ADDR_BUFFER_EVENT: rd_val = ext_status.buffer_event;
			ADDR_IRQ_SOURCE_FLAGS: rd_val = ext_status.irq_source_flags;
			ADDR_DEVICE_IDENTITY: rd_val = IDENTITY_CODE;
			ADDR_RANGE_FILTER_CONTROL: rd_val = s_q.cfg.range_filter_control;
			ADDR_THRESHOLD_CONFIG: rd_val = s_q.cfg.threshold_config;
			ADDR_THRESHOLD_EVENT_FLAGS: rd_val = ext_status.threshold_event_flags;
			ADDR_THRESHOLD_LEVEL: rd_val = s_q.cfg.threshold_level;
			ADDR_THRESHOLD_DEBOUNCE: rd_val = s_q.cfg.threshold_debounce;
			ADDR_TEMPERATURE: rd_val = ext_status.temperature;
			ADDR_MODE_RATE_CONTROL: rd_val = s_q.cfg.mode_rate_control;
			ADDR_IRQ_CONFIG_CONTROL: rd_val = s_q.cfg.irq_config_control;
			ADDR_WRAP_POWER_RANGE_CONTROL: rd_val = s_q.cfg.wrap_power_range_control;
			default: rd_val = RST_ZERO; // reserved space reads zero
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.pop = 1'b0;
		s_d.srst = 1'b0;

		// new sample raises flags; only in bypass do its high bytes land in the output registers, low bytes wait in live_low
		if (drain) begin
			if (bypass) begin
				s_d.out[5] = fifo_out[47:40];
				s_d.out[3] = fifo_out[31:24];
				s_d.out[1] = fifo_out[15:8];
				s_d.live_low[0] = fifo_out[39:32];
				s_d.live_low[1] = fifo_out[23:16];
				s_d.live_low[2] = fifo_out[7:0];
			end
			s_d.dr[XOW_BIT] = s_q.dr[XOW_BIT] | s_q.dr[XDR_BIT];
			s_d.dr[YOW_BIT] = s_q.dr[YOW_BIT] | s_q.dr[YDR_BIT];
			s_d.dr[ZOW_BIT] = s_q.dr[ZOW_BIT] | s_q.dr[ZDR_BIT];
			s_d.dr[ZYXOW_BIT] = s_q.dr[ZYXOW_BIT] | s_q.dr[ZYXDR_BIT];
		end

		// high-byte reads clear flags unless a sample lands in the same cycle
		if (hi_read) begin
			case (axis_hi_read)
				2'd0: begin
					if (!drain) begin
						s_d.dr[XDR_BIT] = 1'b0;
						s_d.dr[XOW_BIT] = 1'b0;
					end
					if (bypass) begin
						s_d.out[4] = s_q.live_low[0];
					end else begin
						s_d.out[4:0] = head_bytes[39:0];
						s_d.out[5] = head_bytes[47:40];
					end
				end
				2'd1: begin
					if (!drain) begin
						s_d.dr[YDR_BIT] = 1'b0;
						s_d.dr[YOW_BIT] = 1'b0;
					end
					if (bypass) begin
						s_d.out[2] = s_q.live_low[1];
					end
				end
				2'd2: begin
					if (!drain) begin
						s_d.dr[ZDR_BIT] = 1'b0;
						s_d.dr[ZOW_BIT] = 1'b0;
					end
					if (bypass) begin
						s_d.out[0] = s_q.live_low[2];
					end else begin
						s_d.pop = 1'b1;
					end
				end
				default: s_d.pop = 1'b0;
			endcase
		end
		if (drain) begin
			s_d.dr[XDR_BIT] = 1'b1;
			s_d.dr[YDR_BIT] = 1'b1;
			s_d.dr[ZDR_BIT] = 1'b1;
		end
		s_d.dr[ZYXDR_BIT] = s_d.dr[XDR_BIT] | s_d.dr[YDR_BIT] | s_d.dr[ZDR_BIT];
		if (!drain && !s_d.dr[ZYXDR_BIT]) begin
			s_d.dr[ZYXOW_BIT] = 1'b0;
		end

		// two-entry buffer in front of the output registers
		case ({smp_valid && smp_ready, drain})
			2'b10: begin
				s_d.fifo[s_q.count[0]] = smp_data;
				s_d.count = s_q.count + 2'd1;
			end
			2'b01: begin
				s_d.fifo[0] = s_q.fifo[1];
				s_d.count = s_q.count - 2'd1;
			end
			2'b11: begin
				s_d.fifo[0] = (s_q.count == 2'd1) ? smp_data : s_q.fifo[1];
				s_d.fifo[1] = smp_data;
			end
			default: s_d.count = s_q.count;
		endcase

		// register access and auto-increment
		case (s_q.xfer)
			XFER_IDLE: begin
				if (acc_start) begin
					s_d.ptr = acc_addr;
					s_d.xfer = XFER_BURST;
				end
			end
			XFER_BURST: begin
				if (acc_stop) begin
					s_d.xfer = XFER_IDLE;
				end else if (acc_start) begin
					s_d.ptr = acc_addr;
				end else if (acc_rd) begin
					s_d.rdata = rd_val;
					s_d.rvalid = 1'b1;
					s_d.ptr = next_addr(s_q.ptr, s_q.cfg.wrap_power_range_control[WRAP_TO_FIRST_SAMPLE_BIT]);
				end else if (acc_wr) begin
					s_d.ptr = next_addr(s_q.ptr, s_q.cfg.wrap_power_range_control[WRAP_TO_FIRST_SAMPLE_BIT]);
					case (s_q.ptr)
						ADDR_BUFFER_SETUP: s_d.cfg.buffer_setup = acc_wdata;
						ADDR_RANGE_FILTER_CONTROL: s_d.cfg.range_filter_control = acc_wdata;
						ADDR_THRESHOLD_CONFIG: s_d.cfg.threshold_config = acc_wdata;
						ADDR_THRESHOLD_LEVEL: s_d.cfg.threshold_level = acc_wdata;
						ADDR_THRESHOLD_DEBOUNCE: s_d.cfg.threshold_debounce = acc_wdata;
						ADDR_MODE_RATE_CONTROL: begin
							if (acc_wdata[SOFT_RESET_BIT]) begin
								// output registers deliberately keep their contents
								s_d.cfg = config_reset();
								s_d.srst = 1'b1;
							end else begin
								s_d.cfg.mode_rate_control = acc_wdata;
							end
						end
						ADDR_IRQ_CONFIG_CONTROL: s_d.cfg.irq_config_control = acc_wdata;
						ADDR_WRAP_POWER_RANGE_CONTROL: s_d.cfg.wrap_power_range_control = acc_wdata;
						default: s_d.cfg = s_q.cfg;
					endcase
				end
			end
			default: s_d.xfer = XFER_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync2_q) begin
		if (!rst_sync2_q) begin
			s_q <= '0;
			s_q.cfg.threshold_debounce <= RST_THRESHOLD_DEBOUNCE;
			s_q.out <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign acc_rdata = s_q.rdata;
	assign acc_rvalid = s_q.rvalid;
	assign acc_ptr = s_q.ptr;
	assign head_pop = s_q.pop;
	assign cfg = s_q.cfg;
	assign soft_reset_pulse = s_q.srst;
endmodule : gyro_register_map_readout

// ==== include/gyro_regs_pkg.sv ====
// constants, field layouts and carrier types for the rate sensor register map
package gyro_regs_pkg;
	localparam logic [7:0] ADDR_STATUS_ALIAS = 8'h00;
	localparam logic [7:0] ADDR_X_RATE_HIGH = 8'h01;
	localparam logic [7:0] ADDR_X_RATE_LOW = 8'h02;
	localparam logic [7:0] ADDR_Y_RATE_HIGH = 8'h03;
	localparam logic [7:0] ADDR_Y_RATE_LOW = 8'h04;
	localparam logic [7:0] ADDR_Z_RATE_HIGH = 8'h05;
	localparam logic [7:0] ADDR_Z_RATE_LOW = 8'h06;
	localparam logic [7:0] ADDR_SAMPLE_READY_STATUS = 8'h07;
	localparam logic [7:0] ADDR_BUFFER_STATUS = 8'h08;
	localparam logic [7:0] ADDR_BUFFER_SETUP = 8'h09;
	localparam logic [7:0] ADDR_BUFFER_EVENT = 8'h0a;
	localparam logic [7:0] ADDR_IRQ_SOURCE_FLAGS = 8'h0b;
	localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h0c;
	localparam logic [7:0] ADDR_RANGE_FILTER_CONTROL = 8'h0d;
	localparam logic [7:0] ADDR_THRESHOLD_CONFIG = 8'h0e;
	localparam logic [7:0] ADDR_THRESHOLD_EVENT_FLAGS = 8'h0f;
	localparam logic [7:0] ADDR_THRESHOLD_LEVEL = 8'h10;
	localparam logic [7:0] ADDR_THRESHOLD_DEBOUNCE = 8'h11;
	localparam logic [7:0] ADDR_TEMPERATURE = 8'h12;
	localparam logic [7:0] ADDR_MODE_RATE_CONTROL = 8'h13;
	localparam logic [7:0] ADDR_IRQ_CONFIG_CONTROL = 8'h14;
	localparam logic [7:0] ADDR_WRAP_POWER_RANGE_CONTROL = 8'h15;

	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_THRESHOLD_DEBOUNCE = 8'h01;

	// field positions
	localparam int BUF_MODE_LSB = 6;
	localparam logic [1:0] BUF_MODE_BYPASS = 2'b00;
	localparam int WRAP_TO_FIRST_SAMPLE_BIT = 3;
	localparam int SOFT_RESET_BIT = 6;
	// sample-ready status bit positions
	localparam int XDR_BIT = 0;
	localparam int YDR_BIT = 1;
	localparam int ZDR_BIT = 2;
	localparam int ZYXDR_BIT = 3;
	localparam int XOW_BIT = 4;
	localparam int YOW_BIT = 5;
	localparam int ZOW_BIT = 6;
	localparam int ZYXOW_BIT = 7;

	localparam int BUF_DEPTH = 2;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} sample_s;

	// writable configuration, presented to the rest of the device
	typedef struct packed {
		logic [7:0] buffer_setup;
		logic [7:0] range_filter_control;
		logic [7:0] threshold_config;
		logic [7:0] threshold_level;
		logic [7:0] threshold_debounce;
		logic [7:0] mode_rate_control;
		logic [7:0] irq_config_control;
		logic [7:0] wrap_power_range_control;
	} config_s;

	// read-only status produced by blocks outside this one
	typedef struct packed {
		logic [7:0] buffer_status;
		logic [7:0] buffer_event;
		logic [7:0] irq_source_flags;
		logic [7:0] threshold_event_flags;
		logic [7:0] temperature;
	} ext_status_s;

	typedef enum logic {
		XFER_IDLE = 1'b0,
		XFER_BURST = 1'b1
	} xfer_e;
endpackage : gyro_regs_pkg

// ==== dv/gyro_map_chk_sva.sv ====
// assertions on the access port of the rate sensor register map
`timescale 1ns/1ps
module gyro_map_chk import gyro_regs_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic acc_start,
	input wire logic [7:0] acc_addr,
	input wire logic acc_stop,
	input wire logic acc_rd,
	input wire logic acc_wr,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_rvalid,
	input wire logic [7:0] acc_ptr,
	input wire logic head_pop,
	input wire config_s cfg,
	input wire logic soft_reset_pulse
);
	logic open_q;
	logic ok;
	logic zrd;
	// stop beats start, as on the access port during a burst; from idle the port opens on start even with stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_q <= 1'b0;
		end else if (acc_start || acc_stop) begin
			open_q <= !acc_stop;
		end
	end
	assign ok = open_q && !acc_start && !acc_stop && (acc_rd || acc_wr);
	assign zrd = ok && acc_rd && acc_ptr == 8'h05 && cfg.buffer_setup[7:6] != 2'b00;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_answer_a: assert property (ok && acc_rd |=> acc_rvalid) else $error("read not answered");
	rvalid_cause_a: assert property (acc_rvalid |-> $past(ok && acc_rd)) else $error("stray read answer");
	ptr_load_a: assert property (acc_start && !acc_stop |=> acc_ptr == $past(acc_addr))
		else $error("start address not loaded");
	z_wrap_a: assert property (ok && acc_ptr == 8'h06 |=> acc_ptr == {7'h00, $past(cfg.wrap_power_range_control[3])})
		else $error("wrong step after z low");
	last_wrap_a: assert property (ok && acc_ptr == 8'h15 |=> acc_ptr == 8'h00) else $error("no wrap after 0x15");
	ptr_step_a: assert property (ok && acc_ptr != 8'h06 && acc_ptr != 8'h15 |=> acc_ptr == $past(acc_ptr) + 8'h01)
		else $error("pointer did not step");
	pop_cause_a: assert property (head_pop |-> $past(zrd)) else $error("pop without z high read");
	pop_follow_a: assert property (zrd |=> head_pop ##1 !head_pop) else $error("z high read did not pop once");
	ro_write_a: assert property (ok && !acc_rd && !(acc_ptr inside {8'h09, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13,
		8'h14, 8'h15}) |=> $stable(cfg)) else $error("write to fixed place changed config");
	srst_load_a: assert property (ok && !acc_rd && acc_ptr == 8'h13 && acc_wdata[6] |=> soft_reset_pulse
		&& cfg == 64'h0000_0000_0100_0000) else $error("soft reset did not restore defaults");
endmodule : gyro_map_chk
bind gyro_register_map_readout gyro_map_chk i_gyro_map_chk (.clk(clk), .rst_n(rst_n), .acc_start(acc_start),
	.acc_addr(acc_addr), .acc_stop(acc_stop), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
	.acc_rvalid(acc_rvalid), .acc_ptr(acc_ptr), .head_pop(head_pop), .cfg(cfg),
	.soft_reset_pulse(soft_reset_pulse));

// ==== dv/host_bfm.sv ====
// host-side driver of the register access strobes
`timescale 1ns/1ps
module host_bfm (
	input wire logic clk,
	output logic acc_start,
	output logic [7:0] acc_addr,
	output logic acc_stop,
	output logic acc_rd,
	output logic acc_wr,
	output logic [7:0] acc_wdata
);
	initial begin
		{acc_start, acc_stop, acc_rd, acc_wr, acc_addr, acc_wdata} = '0;
	end
	// unused buses carry the inverse so a stale value never looks valid
	task automatic step(input logic [3:0] k, input logic [7:0] a);
		@(posedge clk);
		{acc_start, acc_stop, acc_rd, acc_wr} <= k;
		acc_addr <= k[3] ? a : ~a;
		acc_wdata <= k[0] ? a : ~a;
	endtask : step
endmodule : host_bfm

// ==== dv/test_gyro_register_map_readout.sv ====
// self-checking bench of the rate sensor register map and read-out
`timescale 1ns/1ps
`define CMP(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_gyro_register_map_readout;
	import gyro_regs_pkg::*;
	logic clk, rst_n, smp_valid, acc_start, acc_stop, acc_rd, acc_wr, acc_rvalid, smp_ready, head_pop, srp;
	logic [7:0] acc_addr, acc_wdata, acc_rdata, acc_ptr, e;
	logic [7:0] wv [13];
	logic [7:0] exp_q [$];
	logic [1:0] hidx = 2'd0;
	int errors = 0;
	int num_checks = 0;
	int srst_seen = 0;
	int seed = 32'h6aeb74d1;
	sample_s smp_data, head_data;
	sample_s hd [4];
	sample_s sv [3];
	ext_status_s ext_status;
	config_s cfg;
	assign head_data = hd[hidx];
	gyro_register_map_readout #(.IDENTITY_CODE(8'h3c)) i_gyro_register_map_readout (.clk(clk), .rst_n(rst_n),
		.acc_start(acc_start), .acc_addr(acc_addr), .acc_stop(acc_stop), .acc_rd(acc_rd), .acc_wr(acc_wr),
		.acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .acc_ptr(acc_ptr),
		.smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready), .head_data(head_data),
		.head_pop(head_pop), .ext_status(ext_status), .cfg(cfg), .soft_reset_pulse(srp));
	host_bfm i_host_bfm (.clk(clk), .acc_start(acc_start), .acc_addr(acc_addr), .acc_stop(acc_stop),
		.acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (acc_rvalid === 1'b1) begin
			e = exp_q.pop_front();
			`CMP(acc_rdata, e)
		end
		if (head_pop === 1'b1) begin
			hidx <= hidx + 2'd1;
		end
		if (srp === 1'b1) begin
			srst_seen++;
		end
	end
	function automatic logic [7:0] rst_val(input logic [7:0] a);
		case (a)
			8'h08: return ext_status.buffer_status;
			8'h0a: return ext_status.buffer_event;
			8'h0b: return ext_status.irq_source_flags;
			8'h0c: return 8'h3c;
			8'h0f: return ext_status.threshold_event_flags;
			8'h11: return 8'h01;
			8'h12: return ext_status.temperature;
			default: return 8'h00;
		endcase
	endfunction : rst_val
	task automatic burst(input logic [7:0] a, input int n, input logic wr);
		i_host_bfm.step(4'b1000, a);
		for (int i = 0; i < n; i++) i_host_bfm.step(wr ? 4'b0001 : 4'b0010, wv[i % 13]);
		i_host_bfm.step(4'b0100, 8'h00);
		i_host_bfm.step(4'b0000, 8'h00);
	endtask : burst
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	initial begin
		#40000;
		errors++;
		final_report();
	end
	initial begin
		rst_n = 1'b0;
		smp_valid = 1'b0;
		smp_data = '0;
		ext_status = 40'({$random(seed), $random(seed)});
		for (int i = 0; i < 4; i++) hd[i] = 48'({$random(seed), $random(seed)});
		for (int i = 0; i < 3; i++) sv[i] = 48'({$random(seed), $random(seed)});
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// the pointer leaves 0x06 for 0x00, so the map is read in two bursts
		for (int i = 0; i < 22; i++) begin
			exp_q.push_back(rst_val(8'(i)));
			if (i == 6) exp_q.push_back(8'h00);
		end
		exp_q.push_back(8'h00);
		burst(8'h00, 8, 1'b0);
		burst(8'h07, 16, 1'b0);
		for (int i = 0; i < 13; i++) wv[i] = 8'($random(seed));
		wv[0][7:6] = 2'b00;
		wv[10][6] = 1'b0;
		wv[12][3] = 1'b1;
		burst(8'h09, 13, 1'b1);
		for (int i = 0; i < 13; i++) exp_q.push_back(8'(9 + i) inside {8'h09, 8'h0d, 8'h0e, 8'h10, 8'h11, 8'h13,
			8'h14, 8'h15} ? wv[i] : rst_val(8'(9 + i)));
		burst(8'h09, 13, 1'b0);
		burst(8'h20, 1, 1'b1);
		exp_q.push_back(8'h00);
		burst(8'h20, 1, 1'b0);
		i_host_bfm.step(4'b1000, 8'h07);
		fork
			begin
				for (int i = 0; i < 3; i++) begin
					smp_valid <= 1'b1;
					smp_data <= sv[i];
					@(posedge clk);
					while (smp_ready !== 1'b1) @(posedge clk);
				end
				smp_valid <= 1'b0;
			end
			begin
				repeat (6) @(negedge clk);
				`CMP(smp_ready, 1'b0)
				i_host_bfm.step(4'b0100, 8'h00);
				i_host_bfm.step(4'b0000, 8'h00);
			end
		join
		repeat (4) @(posedge clk);
		exp_q.push_back(8'hff);
		for (int i = 0; i < 3; i++) begin
			exp_q.push_back(sv[2][47 - 16 * i -: 8]);
			exp_q.push_back(sv[2][39 - 16 * i -: 8]);
		end
		exp_q.push_back(sv[2][47:40]);
		burst(8'h00, 8, 1'b0);
		exp_q.push_back(8'h00);
		burst(8'h00, 1, 1'b0);
		wv[0] = 8'h40;
		burst(8'h09, 1, 1'b1);
		exp_q.push_back(ext_status.buffer_status);
		for (int i = 0; i < 12; i++) exp_q.push_back(hd[i / 6][47 - 8 * (i % 6) -: 8]);
		burst(8'h00, 13, 1'b0);
		`CMP(hidx, 2'd2)
		wv[0] = 8'h40;
		burst(8'h13, 1, 1'b1);
		for (int i = 0; i < 13; i++) exp_q.push_back(rst_val(8'(9 + i)));
		burst(8'h09, 13, 1'b0);
		`CMP(srst_seen, 1)
		final_report();
	end
endmodule : test_gyro_register_map_readout
